// file: rtl/energy_pulse_gen.sv
/*
 * Energy-to-pulse converter: accumulates a per-cycle energy step and emits
 * an active-low pulse on each accumulator overflow past the threshold that comes while no pulse is in progress.
 * Assumes the step is a same-clock level from the metering engine.
 */
`timescale 1ns/100ps
module energy_pulse_gen
	import meter_pkg::*;
#(
	parameter int ACC_W  = ACC_W_DEF,
	parameter int STEP_W = STEP_W_DEF
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic [STEP_W-1:0] energy_step,
	input  wire logic [ACC_W-1:0]  threshold,
	output logic                   pulse_n
);
	localparam int CNT_W = $clog2(PULSE_CYCLES + 1);
	localparam logic [CNT_W-1:0] PULSE_LEN = CNT_W'(PULSE_CYCLES);

	logic [ACC_W:0]     acc_reg;
	logic [ACC_W:0]     acc_sum;
	logic [CNT_W-1:0]   width_cnt_reg;
	logic               fire;

	assign acc_sum = acc_reg + (ACC_W+1)'(energy_step);
	assign fire    = (threshold != '0) && (acc_sum >= {1'b0, threshold});

	always_ff @(posedge clk) begin
		if (rst) begin
			acc_reg <= '0;
		end else if (fire) begin
			acc_reg <= acc_sum - {1'b0, threshold};
		end else begin
			acc_reg <= acc_sum;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			width_cnt_reg <= '0;
			pulse_n       <= RST_PULSE_N;
		end else if (width_cnt_reg != '0) begin
			width_cnt_reg <= width_cnt_reg - CNT_W'(1);
			pulse_n       <= (width_cnt_reg == CNT_W'(1));
		end else if (fire) begin
			width_cnt_reg <= PULSE_LEN;
			pulse_n       <= 1'b0;
		end else begin
			pulse_n       <= 1'b1;
		end
	end

	// low-time counter for the width checks, saturates at the pulse length
	logic [CNT_W-1:0]   low_run_reg;

	always_ff @(posedge clk) begin
		if (rst || pulse_n) begin
			low_run_reg <= '0;
		end else if (low_run_reg != PULSE_LEN) begin
			low_run_reg <= low_run_reg + CNT_W'(1);
		end
	end

	AST_PULSE_WIDTH: assert property (@(posedge clk) disable iff (rst)
		$rose(pulse_n) |-> low_run_reg == PULSE_LEN)
		else $error("energy pulse too short");
	AST_PULSE_MAX: assert property (@(posedge clk) disable iff (rst)
		low_run_reg == PULSE_LEN |-> pulse_n)
		else $error("energy pulse too long");
endmodule // energy_pulse_gen

// file: rtl/meter_pin_if_top.sv
/*
 * Host pin interface of a four-channel metering device: serial port,
 * interrupt, boot-mode strap, energy pulses, host clock and low-supply flag.
 * Assumes one 10 MHz clock; pins arrive asynchronously; event, mask and
 * energy inputs come from device logic on the same clock.
 */
// Behaviour
// - port active only while chip select low
// - data out high-impedance while chip select high
// - each serial clock shifts in and out
// - three wires plus chip select, SPI-compatible
// - boot-mode high enables auto-boot, default low
// - reset pin low resets all registers
// - interrupt low on enabled pending event
// - three active-low pulse outputs, rate proportional
// - supply monitor trip sets low-supply status flag
// - oscillator clock presented on host clock pin
// - flag sets below low, clears above high
// - host clock same frequency as master
`timescale 1ns/100ps
module meter_pin_if_top
	import meter_pkg::*;
#(
	parameter int WORD_W   = WORD_W_DEF,
	parameter int N_EVENTS = N_EVENTS_DEF,
	parameter int ACC_W    = ACC_W_DEF,
	parameter int STEP_W   = STEP_W_DEF
) (
	input  wire logic                            CLK_SYS,
	input  wire logic                            SYS_RST,
	input  wire logic                            RESET_N,
	input  wire meter_pkg::serial_pins_s         SERIAL_PINS,
	input  wire meter_pkg::misc_pins_s           MISC_PINS,
	input  wire logic [WORD_W-1:0]               TX_WORD,
	input  wire logic [N_EVENTS-1:0]             EVENT_SET,
	input  wire logic [N_EVENTS-1:0]             EVENT_CLEAR,
	input  wire logic [N_EVENTS-1:0]             EVENT_MASK,
	input  wire logic [meter_pkg::N_ENERGY*STEP_W-1:0] ENERGY_STEP,
	input  wire logic [ACC_W-1:0]                ENERGY_THRESHOLD,
	output logic                                 SERIAL_OUT,
	output logic                                 SERIAL_OUT_OE,
	output logic [WORD_W-1:0]                    RX_WORD,
	output logic                                 RX_VALID,
	output logic                                 TX_LOAD,
	output logic                                 INT_N,
	output logic [N_EVENTS-1:0]                  STATUS,
	output logic                                 LOW_SUPPLY_FLAG,
	output logic                                 AUTOBOOT_EN,
	output logic                                 ENERGY_PULSE_A_N,
	output logic                                 ENERGY_PULSE_B_N,
	output logic                                 ENERGY_PULSE_FAST_N,
	output logic                                 HOST_CLOCK_OUT
);
	import meter_pkg::*;

	localparam int BC_W = $clog2(WORD_W);
	localparam logic [BC_W-1:0] LAST_BIT = BC_W'(WORD_W - 1);

	logic               reset_pin_n;
	logic               rst;
	serial_pins_s       ser_s;
	misc_pins_s         misc_s;
	logic               sclk_prev_reg;
	logic               cs_prev_reg;
	logic               sclk_rise;
	logic               sclk_fall;
	logic               cs_fall;
	logic [BC_W-1:0]    bit_cnt_reg;
	logic [WORD_W-1:0]  rx_shift_reg;
	logic [WORD_W-1:0]  tx_shift_reg;
	logic [N_EVENTS-1:0] status_next;
	logic [N_EVENTS-1:0] ev_set;
	logic               clk_pos_reg;
	logic               clk_neg_reg;
	logic [N_ENERGY-1:0] pulse_n;

	pin_sync #(.W(1), .INIT(1'b1)) u_reset_sync (
		.clk       (CLK_SYS),
		.rst       (SYS_RST),
		.pin_in    (RESET_N),
		.level_out (reset_pin_n)
	);

	assign rst = SYS_RST | ~reset_pin_n;

	pin_sync #(.W(3), .INIT({RST_CS_N, 1'b0, 1'b0})) u_serial_sync (
		.clk       (CLK_SYS),
		.rst       (rst),
		.pin_in    (SERIAL_PINS),
		.level_out (ser_s)
	);

	pin_sync #(.W(3), .INIT(3'h0)) u_misc_sync (
		.clk       (CLK_SYS),
		.rst       (rst),
		.pin_in    (MISC_PINS),
		.level_out (misc_s)
	);

	assign sclk_rise = ~ser_s.cs_n & ser_s.sclk & ~sclk_prev_reg;
	assign sclk_fall = ~ser_s.cs_n & ~ser_s.sclk & sclk_prev_reg;
	assign cs_fall   = cs_prev_reg & ~ser_s.cs_n;

	always_ff @(posedge CLK_SYS) begin
		if (rst) begin
			sclk_prev_reg <= 1'b0;
			cs_prev_reg   <= RST_CS_N;
		end else begin
			sclk_prev_reg <= ser_s.sclk;
			cs_prev_reg   <= ser_s.cs_n;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (rst || ser_s.cs_n) begin
			bit_cnt_reg  <= '0;
			rx_shift_reg <= '0;
			RX_VALID     <= 1'b0;
		end else if (sclk_rise) begin
			rx_shift_reg <= {rx_shift_reg[WORD_W-2:0], ser_s.din};
			bit_cnt_reg  <= (bit_cnt_reg == LAST_BIT) ? '0 : bit_cnt_reg + BC_W'(1);
			RX_VALID     <= (bit_cnt_reg == LAST_BIT);
		end else begin
			RX_VALID     <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (rst) begin
			RX_WORD <= '0;
		end else if (sclk_rise && bit_cnt_reg == LAST_BIT) begin
			RX_WORD <= {rx_shift_reg[WORD_W-2:0], ser_s.din};
		end
	end

	// transmit msb first, change on falling clock
	always_ff @(posedge CLK_SYS) begin
		if (rst) begin
			tx_shift_reg <= '0;
			SERIAL_OUT   <= 1'b0;
			TX_LOAD      <= 1'b0;
		end else if (cs_fall || (sclk_fall && bit_cnt_reg == '0)) begin
			tx_shift_reg <= TX_WORD;
			SERIAL_OUT   <= TX_WORD[WORD_W-1];
			TX_LOAD      <= 1'b1;
		end else if (sclk_fall) begin
			tx_shift_reg <= {tx_shift_reg[WORD_W-2:0], 1'b0};
			SERIAL_OUT   <= tx_shift_reg[WORD_W-2];
			TX_LOAD      <= 1'b0;
		end else begin
			TX_LOAD      <= 1'b0;
		end
	end

	// enable right after select, drop on release
	always_ff @(posedge CLK_SYS) begin
		if (rst || ser_s.cs_n) begin
			SERIAL_OUT_OE <= 1'b0;
		end else begin
			SERIAL_OUT_OE <= 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (rst) begin
			AUTOBOOT_EN <= RST_BOOT;
		end else begin
			AUTOBOOT_EN <= misc_s.boot_mode;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (rst) begin
			LOW_SUPPLY_FLAG <= RST_LSD;
		end else if (misc_s.supply_below_low) begin
			LOW_SUPPLY_FLAG <= 1'b1;
		end else if (misc_s.supply_above_high) begin
			LOW_SUPPLY_FLAG <= 1'b0;
		end
	end

	// low-supply trip is a status event
	always_comb begin
		ev_set = EVENT_SET;
		ev_set[STAT_LSD_BIT] = EVENT_SET[STAT_LSD_BIT] | misc_s.supply_below_low;
	end

	// set wins over clear
	assign status_next = (STATUS & ~EVENT_CLEAR) | ev_set;

	always_ff @(posedge CLK_SYS) begin
		if (rst) begin
			STATUS <= '0;
		end else begin
			STATUS <= status_next;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (rst) begin
			INT_N <= RST_INT_N;
		end else begin
			INT_N <= ~|(STATUS & EVENT_MASK);
		end
	end

	genvar g;
	generate
		for (g = 0; g < N_ENERGY; g++) begin : g_energy
			energy_pulse_gen #(.ACC_W(ACC_W), .STEP_W(STEP_W)) u_pulse (
				.clk         (CLK_SYS),
				.rst         (rst),
				.energy_step (ENERGY_STEP[g*STEP_W +: STEP_W]),
				.threshold   (ENERGY_THRESHOLD),
				.pulse_n     (pulse_n[g])
			);
		end
	endgenerate

	assign ENERGY_PULSE_A_N    = pulse_n[0];
	assign ENERGY_PULSE_B_N    = pulse_n[1];
	assign ENERGY_PULSE_FAST_N = pulse_n[2];

	always_ff @(posedge CLK_SYS) begin
		if (rst) begin
			clk_pos_reg <= 1'b0;
		end else begin
			clk_pos_reg <= ~clk_pos_reg;
		end
	end

	always_ff @(negedge CLK_SYS) begin
		if (rst) begin
			clk_neg_reg <= 1'b0;
		end else begin
			clk_neg_reg <= clk_pos_reg;
		end
	end

	assign HOST_CLOCK_OUT = clk_pos_reg ^ clk_neg_reg;

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (rst);

	AST_SO_HIZ_DESELECT: assert property (ser_s.cs_n |=> !SERIAL_OUT_OE)
		else $error("data out driven while deselected");
	AST_SO_DRIVE_AFTER_SELECT: assert property (cs_fall |=> SERIAL_OUT_OE && TX_LOAD
		&& SERIAL_OUT == $past(TX_WORD[WORD_W-1]))
		else $error("data out not driven after select");
	AST_IGNORE_DESELECTED: assert property (ser_s.cs_n ##1 ser_s.cs_n |-> !RX_VALID && bit_cnt_reg == '0)
		else $error("serial activity while deselected");
	AST_ONE_BIT_PER_CLOCK: assert property (sclk_rise && bit_cnt_reg != LAST_BIT
		|=> bit_cnt_reg == $past(bit_cnt_reg) + BC_W'(1) && rx_shift_reg[0] == $past(ser_s.din))
		else $error("receive shift wrong");
	AST_INT_ENABLED: assert property (|(STATUS & EVENT_MASK) |=> !INT_N)
		else $error("interrupt missing for enabled event");
	AST_INT_RELEASE: assert property (!(|(STATUS & EVENT_MASK)) |=> INT_N)
		else $error("interrupt held without enabled event");
	AST_LSD_SET: assert property (misc_s.supply_below_low |=> LOW_SUPPLY_FLAG && STATUS[STAT_LSD_BIT])
		else $error("low-supply not flagged");
	AST_LSD_HOLD: assert property (LOW_SUPPLY_FLAG && !misc_s.supply_above_high |=> LOW_SUPPLY_FLAG)
		else $error("low-supply flag cleared early");
	AST_BOOT_FOLLOW: assert property (misc_s.boot_mode |=> AUTOBOOT_EN)
		else $error("auto-boot not enabled");
	AST_RESET_STATE: assert property (disable iff (1'b0) rst |=> INT_N && !SERIAL_OUT_OE
		&& !LOW_SUPPLY_FLAG && STATUS == '0)
		else $error("reset state wrong");
	AST_SET_OVER_CLEAR: assert property (EVENT_SET[1] && EVENT_CLEAR[1] |=> STATUS[1])
		else $error("event lost on clear");
	AST_TX_RELOAD: assert property (sclk_fall && bit_cnt_reg == '0 |=> TX_LOAD
		&& SERIAL_OUT == $past(TX_WORD[WORD_W-1]))
		else $error("next transmit word not loaded");
	AST_RX_WORD_LAND: assert property (sclk_rise && bit_cnt_reg == LAST_BIT |=> RX_VALID
		&& RX_WORD[0] == $past(ser_s.din))
		else $error("received word not delivered");
	AST_SO_RELEASE: assert property ($rose(ser_s.cs_n) |=> !SERIAL_OUT_OE)
		else $error("data out not released on deselect");
	AST_HOST_CLK_TOGGLE: assert property (!rst |=> clk_pos_reg != $past(clk_pos_reg))
		else $error("host clock stalled");
	AST_BOOT_DEFAULT: assert property (!misc_s.boot_mode |=> !AUTOBOOT_EN)
		else $error("auto-boot enabled without strap");
	AST_LSD_CLEAR: assert property (!misc_s.supply_below_low && misc_s.supply_above_high |=> !LOW_SUPPLY_FLAG)
		else $error("low-supply flag not cleared");
	AST_STATUS_STICKY: assert property (STATUS[STAT_LSD_BIT] && !EVENT_CLEAR[STAT_LSD_BIT] |=> STATUS[STAT_LSD_BIT])
		else $error("low-supply status lost");

	COV_WORD_RX: cover property (RX_VALID);
	COV_INT_FIRE: cover property ($fell(INT_N));
	COV_LSD_CYCLE: cover property ($fell(LOW_SUPPLY_FLAG));
	COV_PULSE: cover property ($fell(ENERGY_PULSE_A_N));
	COV_SET_CLEAR: cover property (EVENT_SET[1] && EVENT_CLEAR[1]);
endmodule // meter_pin_if_top

// file: rtl/meter_pkg.sv
/*
 * Shared constants and carrier types for the meter host pin interface.
 * Assumes a single 10 MHz system clock and a synchronous, active-high reset.
 */
package meter_pkg;
	localparam int CLK_PERIOD_NS   = 100;
	localparam int SYNC_STAGES     = 3;
	localparam int WORD_W_DEF      = 8;
	localparam int N_EVENTS_DEF    = 8;
	localparam int N_ENERGY        = 3;
	localparam int ACC_W_DEF       = 24;
	localparam int STEP_W_DEF      = 16;
	// status bit position of the low-supply event
	localparam int STAT_LSD_BIT    = 0;
	// energy pulse low time
	localparam int PULSE_WIDTH_NS  = 1000;
	localparam int PULSE_CYCLES    = (PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic RST_INT_N     = 1'b1;
	localparam logic RST_PULSE_N   = 1'b1;
	localparam logic RST_CS_N      = 1'b1;
	localparam logic RST_LSD       = 1'b0;
	localparam logic RST_BOOT      = 1'b0;

	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic din;
	} serial_pins_s;

	typedef struct packed {
		logic boot_mode;
		logic supply_below_low;
		logic supply_above_high;
	} misc_pins_s;
endpackage

// file: rtl/pin_sync.sv
/*
 * Three-stage pin synchroniser with agreement filter.
 * Assumes asynchronous pin levels; output changes when stages two and three agree.
 */
`timescale 1ns/100ps
module pin_sync #(
	parameter int         W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] level_out
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			s1_reg <= INIT;
			s2_reg <= INIT;
			s3_reg <= INIT;
		end else begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk) begin
				if (rst) begin
					level_out[i] <= INIT[i];
				end else if (s2_reg[i] == s3_reg[i]) begin
					level_out[i] <= s3_reg[i];
				end
			end
		end
	endgenerate
endmodule // pin_sync

// file: tb/host_spi_model.sv
/*
 * Host microcontroller model on the three-wire serial port, mode 0, msb first.
 * Assumes the system clock is given only to pace its bit phases.
 */
`timescale 1ns/100ps
module host_spi_model (
	input  wire logic clk,
	input  wire logic serial_out,
	output logic      cs_n,
	output logic      sclk,
	output logic      din
);
	// each phase outlasts the pin sync filter
	localparam int HALF = 8;

	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din  = 1'b1;
	end

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		cs_n = 1'b0;
		wait_cyc(HALF);
		for (int i = 7; i >= 0; i--) begin
			din = tx[i];
			wait_cyc(HALF);
			rx[i] = serial_out;
			sclk  = 1'b1;
			wait_cyc(HALF);
			sclk = 1'b0;
		end
		wait_cyc(HALF);
		cs_n = 1'b1;
		din  = ~din;
	endtask

	task automatic wiggle(input int n);
		for (int i = 0; i < n; i++) begin
			din  = ~din;
			sclk = 1'b1;
			wait_cyc(HALF);
			sclk = 1'b0;
			wait_cyc(HALF);
		end
	endtask
endmodule // host_spi_model

// file: tb/testbench.sv
/*
 * Self-checking bench for the meter host pin interface.
 * Assumes the host model of tb/ and the package of rtl/.
 */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module testbench;
	import meter_pkg::*;
	logic         clk = 1'b0;
	logic         rst = 1'b1;
	logic         reset_n = 1'b1;
	serial_pins_s spins;
	misc_pins_s   mpins = '0;
	logic [7:0]   tx_word = 8'ha5;
	logic [7:0]   ev_set = '0;
	logic [7:0]   ev_clr = '0;
	logic [7:0]   ev_mask = '0;
	logic [47:0]  step = '0;
	logic [23:0]  thr = 24'h002710;
	logic         serial_out;
	logic         oe;
	logic         dut_out;
	logic         tx_load;
	logic         sdo_last = 1'b0;
	logic         cs_n;
	logic         sclk;
	logic         din;
	logic [7:0]   rx_word;
	logic [7:0]   status;
	logic         rx_valid;
	logic         int_n;
	logic         lsf;
	logic         boot;
	logic         pa;
	logic         pb;
	logic         pf;
	logic         hclk;
	logic [7:0]   got;
	int           errors = 0;
	int           comparisons = 0;
	int           rxn = 0;
	int           hc = 0;
	int           ca = 0;
	int           cb = 0;
	int           cf = 0;
	int           tl = 0;

	initial forever #50 clk = ~clk;
	assign spins = '{cs_n: cs_n, sclk: sclk, din: din};
	// released data line shows the inverse of its last value
	assign serial_out = oe ? dut_out : ~sdo_last;
	always @(posedge clk) if (oe) sdo_last <= dut_out;
	always @(posedge clk) if (tx_load === 1'b1) tl++;
	always @(posedge clk) if (rx_valid === 1'b1) rxn++;
	always @(hclk) hc++;
	always @(negedge pa) ca++;
	always @(negedge pb) cb++;
	always @(negedge pf) cf++;

	host_spi_model host_spi_model_i (.clk(clk), .serial_out(serial_out), .cs_n(cs_n), .sclk(sclk), .din(din));

	meter_pin_if_top meter_pin_if_top_i (
		.CLK_SYS(clk), .SYS_RST(rst), .RESET_N(reset_n), .SERIAL_PINS(spins), .MISC_PINS(mpins),
		.TX_WORD(tx_word), .EVENT_SET(ev_set), .EVENT_CLEAR(ev_clr), .EVENT_MASK(ev_mask),
		.ENERGY_STEP(step), .ENERGY_THRESHOLD(thr), .SERIAL_OUT(dut_out), .SERIAL_OUT_OE(oe),
		.RX_WORD(rx_word), .RX_VALID(rx_valid), .TX_LOAD(tx_load), .INT_N(int_n), .STATUS(status),
		.LOW_SUPPLY_FLAG(lsf), .AUTOBOOT_EN(boot), .ENERGY_PULSE_A_N(pa), .ENERGY_PULSE_B_N(pb),
		.ENERGY_PULSE_FAST_N(pf), .HOST_CLOCK_OUT(hclk));

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic t_reset();
		`CHK("int_n", 1'b1, int_n)
		`CHK("oe", 1'b0, oe)
		`CHK("status", 8'h00, status)
		`CHK("pulses", 3'b111, {pa, pb, pf})
		$display("test reset done");
	endtask

	task automatic t_serial();
		int n0;
		int l0;
		n0 = rxn;
		l0 = tl;
		host_spi_model_i.xfer(8'h3c, got);
		cyc(1);
		`CHK("rx_count", n0 + 1, rxn)
		`CHK("rx_word", 8'h3c, rx_word)
		`CHK("tx_bits", 8'ha5, got)
		`CHK("tx_loads", l0 + 2, tl)
		cyc(6);
		`CHK("oe_idle", 1'b0, oe)
		$display("test serial done");
	endtask

	task automatic t_ignore();
		int n0;
		n0 = rxn;
		host_spi_model_i.wiggle(9);
		cyc(6);
		`CHK("rx_ignored", n0, rxn)
		`CHK("oe_desel", 1'b0, oe)
		$display("test deselect done");
	endtask

	task automatic t_events();
		ev_set = 8'h04;
		cyc(1);
		ev_set = 8'h00;
		cyc(3);
		`CHK("stat2", 1'b1, status[2])
		`CHK("int_masked", 1'b1, int_n)
		ev_mask = 8'h04;
		cyc(3);
		`CHK("int_on", 1'b0, int_n)
		ev_clr = 8'h04;
		cyc(1);
		ev_clr = 8'h00;
		cyc(3);
		`CHK("int_off", 1'b1, int_n)
		ev_set = 8'h02;
		ev_clr = 8'h02;
		cyc(1);
		ev_set = 8'h00;
		ev_clr = 8'h00;
		cyc(1);
		`CHK("set_wins", 1'b1, status[1])
		$display("test events done");
	endtask

	task automatic t_supply();
		mpins.supply_below_low = 1'b1;
		cyc(8);
		`CHK("lsf_set", 1'b1, lsf)
		`CHK("stat0", 1'b1, status[0])
		mpins.supply_below_low = 1'b0;
		cyc(8);
		`CHK("lsf_hold", 1'b1, lsf)
		mpins.supply_above_high = 1'b1;
		cyc(8);
		`CHK("lsf_clr", 1'b0, lsf)
		mpins.supply_above_high = 1'b0;
		$display("test supply done");
	endtask

	task automatic t_boot();
		`CHK("boot_off", 1'b0, boot)
		mpins.boot_mode = 1'b1;
		cyc(8);
		`CHK("boot_on", 1'b1, boot)
		mpins.boot_mode = 1'b0;
		cyc(8);
		`CHK("boot_back", 1'b0, boot)
		$display("test boot done");
	endtask

	task automatic t_energy();
		step = {16'h00c8, 16'h0064, 16'h0032};
		ca = 0;
		cb = 0;
		cf = 0;
		cyc(2000);
		step = '0;
		cyc(20);
		`CHK("rate_a", 1'b1, (ca >= 9 && ca <= 11))
		`CHK("rate_b", 1'b1, (cb >= 19 && cb <= 21))
		`CHK("rate_f", 1'b1, (cf >= 39 && cf <= 41))
		$display("test energy done");
	endtask

	task automatic t_hostclk();
		hc = 0;
		cyc(10);
		`CHK("hclk_edges", 20, hc)
		$display("test host clock done");
	endtask

	task automatic t_pinreset();
		ev_set = 8'h08;
		ev_mask = 8'h08;
		cyc(1);
		ev_set = 8'h00;
		cyc(3);
		`CHK("int_pre", 1'b0, int_n)
		reset_n = 1'b0;
		cyc(8);
		`CHK("stat_rst", 8'h00, status)
		`CHK("int_rst", 1'b1, int_n)
		reset_n = 1'b1;
		cyc(10);
		$display("test pin reset done");
	endtask

	initial begin
		cyc(16);
		rst = 1'b0;
		cyc(10);
		t_reset();
		t_serial();
		t_ignore();
		t_events();
		t_supply();
		t_boot();
		t_energy();
		t_hostclk();
		t_pinreset();
		t_serial();
		report_and_stop();
	end

	initial begin
		#(100 * 20000);
		errors++;
		report_and_stop();
	end
endmodule // testbench
